/* src/twa_core.sv */
// thermal window alert core: send byte / receive byte slave and window comparator
// assumes smbus pins are open drain, resolved outside; die temperature is a slow word
// What this block does
// - reset loads the trip threshold with the code for plus one hundred degrees
// - a send byte command carries the new threshold, which the block adopts
// - after reset undertemperature interrupts are masked
// - temperature above trip threshold sets alert latch and over flag
// - a status read while still hot re-asserts alert and flag at once
// - over condition reads back in the msb of the receive byte status
// - each threshold write loads the mask bit from the same command byte
// - a threshold write clears all status flags and releases the alert
// - unmasked, temperature below the low window raises the alert latch
// - writing the mask bit set suppresses low window interrupts again
// - temperature in degrees equals twice the signed threshold code
// - low window threshold sits eight degrees below the trip threshold
// - alert stays latched until a status read or a threshold write
module twa_core
  import twa_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire logic                         smb_clk_i,
  input  wire logic                         smb_dat_i,
  output logic                              smb_dat_o,
  output logic                              smb_dat_oe,
  input  wire logic [6:0]                   slave_addr,
  input  wire logic signed [twa_pkg::TEMP_W-1:0] die_temp,
  output logic                              alert_oe,
  output twa_pkg::twa_cmd_t                 trip_threshold,
  output twa_pkg::twa_status_t              status_byte
);
  import twa_pkg::*;

  // ==========================================
  // pin sampling
  logic [TEMP_W+8:0]   sync_q;
  logic                scl_s;
  logic                sda_s;
  logic [6:0]          addr_s;
  logic signed [TEMP_W-1:0] temp_s;
  logic                scl_d_ff;
  logic                sda_d_ff;

  twa_sync #(.W(TEMP_W + 9)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({~smb_clk_i, ~smb_dat_i, slave_addr, die_temp}),
    .sync_out (sync_q)
  );

  // pins idle high, synchroniser clears low: carried inverted, no false edge after reset
  assign scl_s  = ~sync_q[TEMP_W+8];
  assign sda_s  = ~sync_q[TEMP_W+7];
  assign addr_s = sync_q[TEMP_W+6:TEMP_W];
  assign temp_s = sync_q[TEMP_W-1:0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // ==========================================
  // serial slave
  twa_state_t  state_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  rx_ff;
  logic [7:0]  tx_ff;
  logic        rw_ff;
  logic        wr_commit;
  logic        rd_load;
  logic        status_clr;

  // commit on the eighth falling edge, when the ack slot opens
  assign wr_commit  = (state_ff == ST_WDATA) & scl_fall & (cnt_ff == BIT_LAST);
  assign rd_load    = (state_ff == ST_ADDR_ACK) & scl_fall & rw_ff;
  assign status_clr = wr_commit | rd_load;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= ST_IDLE;
      cnt_ff     <= 4'h0;
      rx_ff      <= 8'h00;
      tx_ff      <= 8'h00;
      rw_ff      <= 1'b0;
      smb_dat_oe <= 1'b0;
    end else if (start_c) begin
      state_ff   <= ST_ADDR;
      cnt_ff     <= 4'h0;
      smb_dat_oe <= 1'b0;
    end else if (stop_c) begin
      state_ff   <= ST_IDLE;
      smb_dat_oe <= 1'b0;
    end else if (scl_rise) begin
      if (state_ff == ST_ADDR || state_ff == ST_WDATA) begin
        rx_ff <= {rx_ff[6:0], sda_s};
      end
      if (cnt_ff != BIT_LAST) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end else if (scl_fall) begin
      unique case (state_ff)
        ST_IDLE, ST_DONE: begin
          smb_dat_oe <= 1'b0;
        end
        ST_ADDR: begin
          if (cnt_ff == BIT_LAST) begin
            if (rx_ff[7:1] == addr_s) begin
              state_ff   <= ST_ADDR_ACK;
              rw_ff      <= rx_ff[0];
              smb_dat_oe <= 1'b1;
            end else begin
              state_ff <= ST_DONE;
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_ff <= 4'h0;
          if (rw_ff) begin
            // snapshot before the read clears the flags
            tx_ff      <= {status_byte[6:0], 1'b0};
            smb_dat_oe <= ~status_byte[ST_OVER_BIT];
            state_ff   <= ST_RDATA;
          end else begin
            smb_dat_oe <= 1'b0;
            state_ff   <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (cnt_ff == BIT_LAST) begin
            smb_dat_oe <= 1'b1;
            state_ff   <= ST_WACK;
          end
        end
        ST_WACK: begin
          smb_dat_oe <= 1'b0;
          state_ff   <= ST_DONE;
        end
        ST_RDATA: begin
          if (cnt_ff == BIT_LAST) begin
            smb_dat_oe <= 1'b0;
            state_ff   <= ST_DONE;
          end else begin
            smb_dat_oe <= ~tx_ff[7];
            tx_ff      <= {tx_ff[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      smb_dat_o <= 1'b0;
    end else begin
      smb_dat_o <= 1'b0;
    end
  end

  // ==========================================
  // threshold and mask
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trip_threshold.thr        <= THR_POR;
      trip_threshold.under_mask <= 1'b1;
    end else if (wr_commit) begin
      trip_threshold.thr        <= rx_ff[THR_W-1:0];
      trip_threshold.under_mask <= rx_ff[CMD_MASK_BIT];
    end
  end

  // ==========================================
  // window comparator
  logic signed [9:0] trip_deg;
  logic signed [9:0] low_deg;
  logic signed [9:0] temp_deg;
  logic              hot;
  logic              cold;
  logic              hot_set;
  logic              cold_set;

  assign trip_deg = 10'($signed({trip_threshold.thr, 1'b0}));
  assign low_deg  = trip_deg - $signed(WINDOW_DEG);
  assign temp_deg = 10'(temp_s);
  assign hot      = temp_deg > trip_deg;
  assign cold     = (temp_deg < low_deg) & ~trip_threshold.under_mask;
  // commit cycle still compares against the old window; its result is dropped
  assign hot_set  = hot & ~wr_commit;
  assign cold_set = cold & ~wr_commit;

  // ==========================================
  // status flags and alert latch; a set beats a read clear, a write retires the old window
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_byte <= STATUS_POR;
      alert_oe    <= 1'b0;
    end else begin
      status_byte.over  <= hot_set | (status_byte.over & ~status_clr);
      status_byte.under <= cold_set | (status_byte.under & ~status_clr);
      // no power-on detector, so the default bit stays low
      status_byte.dflt  <= 1'b0;
      alert_oe <= hot_set | cold_set | (alert_oe & ~status_clr);
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  por_thr_a: assert property (@(posedge core_clk) $rose(rstn) |->
    trip_threshold.thr == THR_POR) else $error("threshold not at reset code");
  por_mask_a: assert property (@(posedge core_clk) $rose(rstn) |->
    trip_threshold.under_mask) else $error("under mask not set after reset");
  over_set_a: assert property (hot && !wr_commit |=> status_byte.over && alert_oe)
    else $error("hot did not set over and alert");
  reassert_a: assert property (rd_load && hot |=> alert_oe && status_byte.over)
    else $error("read while hot lost the alert");
  msb_over_a: assert property (rd_load |=> smb_dat_oe == !$past(status_byte.over))
    else $error("status msb not driven from over flag");
  write_adopt_a: assert property (wr_commit |=>
    trip_threshold == $past(rx_ff)) else $error("threshold write not adopted");
  write_clear_a: assert property (wr_commit |=>
    !alert_oe && !status_byte.over && !status_byte.under) else $error("write did not clear");
  under_set_a: assert property (cold && !wr_commit |=> alert_oe && status_byte.under)
    else $error("low window did not alert");
  mask_hold_a: assert property (trip_threshold.under_mask && !hot && !alert_oe
    |=> !status_byte.under) else $error("masked low window raised a flag");
  latch_hold_a: assert property (alert_oe && !status_clr |=> alert_oe)
    else $error("alert released without read or write");
  window_gap_a: assert property (!wr_commit && !trip_threshold.under_mask &&
    temp_deg + 10'sd8 < trip_deg |=> status_byte.under)
    else $error("low window not eight degrees below trip");
endmodule : twa_core

/* src/twa_pkg.sv */
// constants, carrier types and states for the thermal window alert core
// assumes a single core clock domain; the serial pins are sampled, not clocked on
package twa_pkg;
  // ==========================================
  // threshold coding
  localparam int          THR_W        = 7;
  localparam int          TEMP_W       = 9;
  localparam logic [6:0]  THR_POR      = 7'h32;   // code 50, twice is +100 degrees
  localparam logic [9:0]  WINDOW_DEG   = 10'h008;
  // ==========================================
  // command byte fields
  localparam int          CMD_MASK_BIT = 7;
  // ==========================================
  // status byte fields and reset value
  localparam int          ST_OVER_BIT  = 7;
  localparam int          ST_UNDER_BIT = 6;
  localparam int          ST_DFLT_BIT  = 1;
  localparam logic [7:0]  STATUS_POR   = 8'h00;
  localparam logic [3:0]  BIT_LAST     = 4'h8;

  typedef struct packed {
    logic             under_mask;
    logic [THR_W-1:0] thr;
  } twa_cmd_t;

  typedef struct packed {
    logic       over;
    logic       under;
    logic       out_mirror;
    logic [2:0] rfu;
    logic       dflt;
    logic       err;
  } twa_status_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_DONE
  } twa_state_t;
endpackage : twa_pkg

/* src/twa_sync.sv */
// two-flop synchroniser for a group of levels from outside the clock domain
// assumes each bit is a slow level; multi-bit words must be stable while sampled
module twa_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  // ==========================================
  // first stage is read only by the second
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : twa_sync

/* test/twa_core_bench.sv */
// self-checking bench for the thermal window alert core
// assumes the host model in its own file; data line pulled up here
module twa_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import twa_pkg::*;
  localparam logic [6:0] ADDR = 7'h4a;
  logic                       core_clk;
  logic                       rstn;
  logic signed [TEMP_W-1:0]   die_temp;
  wire                        smb_clk;
  wire                        host_oe;
  wire                        dat;
  logic                       smb_dat_o;
  logic                       smb_dat_oe;
  logic                       alert_oe;
  twa_cmd_t                   trip_threshold;
  twa_status_t                status_byte;
  logic [7:0]                 rd;
  logic                       ack;
  int                         err_count;
  int                         check_count;
  // wired-and of both open-drain drivers
  assign dat = (smb_dat_oe ? smb_dat_o : 1'b1) & ~host_oe;
  twa_core dut_u (.core_clk(core_clk), .rstn(rstn), .smb_clk_i(smb_clk), .smb_dat_i(dat),
    .smb_dat_o(smb_dat_o), .smb_dat_oe(smb_dat_oe), .slave_addr(ADDR), .die_temp(die_temp),
    .alert_oe(alert_oe), .trip_threshold(trip_threshold), .status_byte(status_byte));
  twa_host_model host_u (.smb_clk(smb_clk), .dat_oe(host_oe), .dat(dat));
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] cmd);
    host_u.xfer({ADDR, 1'b0}, cmd, rd, ack);
    chk("write ack", 9'h001, {8'h00, ack});
    repeat (2) @(negedge core_clk);
  endtask : wr
  task automatic rdst(input logic [7:0] exp);
    host_u.xfer({ADDR, 1'b1}, 8'h00, rd, ack);
    chk("read ack", 9'h001, {8'h00, ack});
    chk("status read", {1'b0, exp}, {1'b0, rd});
    repeat (2) @(negedge core_clk);
  endtask : rdst
  // settle covers both synchroniser flops and the flag flop
  task automatic temp(input int t);
    @(negedge core_clk);
    die_temp = t[8:0];
    repeat (8) @(negedge core_clk);
  endtask : temp
  task automatic end_sim();
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // ==========================================
  // clock, watchdog, sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #1ms;
    err_count++;
    end_sim();
  end
  initial begin
    int tv[2];
    int ex[2];
    int thi;
    int tlo;
    int t;
    tv = '{37, -21};
    ex = '{18, -11};
    err_count = 0;
    check_count = 0;
    rstn = 1'b0;
    die_temp = 9'sh014;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("threshold", 9'h0b2, {1'b0, trip_threshold});
    chk("alert", 9'h000, {8'h00, alert_oe});
    chk("status", 9'h000, {1'b0, status_byte});
    temp(100);
    chk("alert", 9'h000, {8'h00, alert_oe});
    temp(101);
    chk("alert", 9'h001, {8'h00, alert_oe});
    chk("status", 9'h080, {1'b0, status_byte});
    rdst(8'h80);
    chk("alert", 9'h001, {8'h00, alert_oe});
    chk("status", 9'h080, {1'b0, status_byte});
    wr(8'h34);
    chk("threshold", 9'h034, {1'b0, trip_threshold});
    chk("status", 9'h000, {1'b0, status_byte});
    chk("alert", 9'h000, {8'h00, alert_oe});
    temp(96);
    chk("alert", 9'h000, {8'h00, alert_oe});
    temp(95);
    chk("status", 9'h040, {1'b0, status_byte});
    chk("alert", 9'h001, {8'h00, alert_oe});
    rdst(8'h40);
    wr(8'hb4);
    temp(95);
    chk("alert", 9'h000, {8'h00, alert_oe});
    chk("status", 9'h000, {1'b0, status_byte});
    temp(110);
    temp(100);
    repeat (20) @(negedge core_clk);
    chk("alert", 9'h001, {8'h00, alert_oe});
    rdst(8'h80);
    chk("alert", 9'h000, {8'h00, alert_oe});
    // ==========================================
    // reset again in mid-run, then a frame for another address
    rstn = 1'b0;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("threshold", 9'h0b2, {1'b0, trip_threshold});
    host_u.xfer({ADDR ^ 7'h01, 1'b0}, 8'h00, rd, ack);
    chk("foreign ack", 9'h000, {8'h00, ack});
    chk("threshold", 9'h0b2, {1'b0, trip_threshold});
    repeat (2) @(negedge core_clk);
    // ==========================================
    // bit-by-bit search, one warm and one sub-zero die
    for (int k = 0; k < 2; k++) begin
      temp(tv[k]);
      thi = 63;
      tlo = -64;
      while (thi - tlo > 1) begin
        t = (thi + tlo) >>> 1;
        wr({1'b1, t[6:0]});
        repeat (10) @(negedge core_clk);
        host_u.xfer({ADDR, 1'b1}, 8'h00, rd, ack);
        chk("search ack", 9'h001, {8'h00, ack});
        if (rd[7] === 1'b1) begin
          tlo = t;
        end else begin
          thi = t;
        end
      end
      chk("search", 9'(ex[k]), 9'(tlo));
    end
    end_sim();
  end
endmodule : twa_core_bench

/* test/twa_host_model.sv */
// serial bus host model: send byte and receive byte framing, msb first
// assumes the bench resolves the data line with a pull-up
module twa_host_model (
  output logic      smb_clk,
  output logic      dat_oe,
  input  wire logic dat
);
  timeunit 1ns;
  timeprecision 10ps;
  // ==========================================
  // bit level; clock stands high between frames
  initial begin
    smb_clk = 1'b1;
    dat_oe  = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    dat_oe = ~b;
    #31.25 smb_clk = 1'b1;
    #31.25 r = dat;
    #31.25 smb_clk = 1'b0;
    #31.25;
  endtask : bit_io
  // ==========================================
  // one whole frame; read frames release data and nack
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd,
                      output logic ack);
    logic r;
    logic a2;
    // start off the core clock's sampling edges
    #2 dat_oe = 1'b1;
    #62.5 smb_clk = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) bit_io(hdr[i], r);
    bit_io(1'b1, r);
    ack = ~r;
    for (int i = 7; i >= 0; i--) bit_io(hdr[0] | wd[i], rd[i]);
    bit_io(1'b1, a2);
    ack = ack & (hdr[0] | ~a2);
    dat_oe = 1'b1;
    #62.5 smb_clk = 1'b1;
    #62.5 dat_oe = 1'b0;
    #125;
  endtask : xfer
endmodule : twa_host_model
